// file: pdsa_pkg.sv
// Package: constants for program/data space access logic
package pdsa_pkg;
  // Program space
  localparam int PC_W = 23;
  localparam int PADDR_W = 24;
  localparam logic [23:0] USER_LIMIT = 24'h7FFFFF;
  localparam logic [23:0] RESET_ADDR = 24'h000000;
  localparam logic [23:0] START_WORD_ADDR = 24'h000002;
  localparam logic [23:0] VEC_END = 24'h000200;
  localparam logic [23:0] IVT_LO = 24'h000004;
  localparam logic [23:0] IVT_HI = 24'h0000FF;
  localparam logic [23:0] AIVT_LO = 24'h000100;
  localparam logic [23:0] AIVT_HI = 24'h0001FF;
  localparam int TBL_PAGE_CFG_BIT = 7;
  localparam logic [22:0] PC_STEP = 23'h000002;
  // Data space
  localparam int DADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int PSV_BIT = 15;
  localparam int RAM_BYTES = 2048;
  localparam int RAM_WORDS = RAM_BYTES / 2;
  localparam int RAM_AW = 10;
  localparam logic [15:0] RAM_END = 16'h0800;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONES_BYTE = 8'hFF;
  // Working register file
  localparam int NUM_WREG = 16;
  localparam int WREG_AW = 4;
  localparam logic [15:0] WREG_RESET = 16'h0000;
  // Register-file operations
  typedef enum logic [3:0] {
    PDSA_WOP_NONE = 4'h1,
    PDSA_WOP_WORD = 4'h2,
    PDSA_WOP_BYTE = 4'h4,
    PDSA_WOP_EXT = 4'h8
  } pdsa_wop_t;
endpackage

// file: pdsa_data_ram.sv
// Module: byte-laned data memory with shared word decode
`timescale 1ns/1ps
module pdsa_data_ram (
  input wire logic clk_i,
  input wire logic [pdsa_pkg::RAM_AW-1:0] rd_word_i,
  output logic [15:0] rd_data_o,
  input wire logic [pdsa_pkg::RAM_AW-1:0] wr_word_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_lo_i,
  input wire logic wr_hi_i
);
  logic [7:0] lo_mem [pdsa_pkg::RAM_WORDS];
  logic [7:0] hi_mem [pdsa_pkg::RAM_WORDS];

  // Two byte-wide arrays, one word decode, separate write lines
  always_ff @(posedge clk_i) begin
    if (wr_lo_i) begin
      lo_mem[wr_word_i] <= wr_data_i[7:0]; // [RULE14]
    end
    if (wr_hi_i) begin
      hi_mem[wr_word_i] <= wr_data_i[15:8]; // [RULE14]
    end
  end

  // Combinational read so a load completes in its own cycle
  assign rd_data_o = {hi_mem[rd_word_i], lo_mem[rd_word_i]}; // [RULE11]
endmodule

// file: pdsa_wreg_file.sv
// Module: working register file with byte and extend writes
`timescale 1ns/1ps
module pdsa_wreg_file (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [pdsa_pkg::WREG_AW-1:0] rd_sel_i,
  output logic [15:0] rd_data_o,
  input wire logic [pdsa_pkg::WREG_AW-1:0] wr_sel_i,
  input wire pdsa_pkg::pdsa_wop_t wr_op_i,
  input wire logic [15:0] wr_data_i
);
  logic [15:0] wreg_ff [pdsa_pkg::NUM_WREG];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < pdsa_pkg::NUM_WREG; i++) begin
        wreg_ff[i] <= pdsa_pkg::WREG_RESET;
      end
    end else begin
      unique case (wr_op_i)
        pdsa_pkg::PDSA_WOP_NONE: begin
        end
        pdsa_pkg::PDSA_WOP_WORD: begin
          wreg_ff[wr_sel_i] <= wr_data_i;
        end
        pdsa_pkg::PDSA_WOP_BYTE: begin
          wreg_ff[wr_sel_i][7:0] <= wr_data_i[7:0]; // [RULE17]
        end
        pdsa_pkg::PDSA_WOP_EXT: begin
          wreg_ff[wr_sel_i] <= wr_data_i; // [RULE18]
        end
        default: begin
        end
      endcase
    end
  end

  assign rd_data_o = wreg_ff[rd_sel_i];
endmodule

// file: pdsa_core_access.sv
// Module: program and data space address mapping and access control
// What this block does
// RULE1: Program address is 24 bits, from 23-bit counter or table access.
// RULE2: User reach is lower half; config half only via page bit 7 tables. tbl_allowed_o does not check the page bit.
// RULE3: Program location is lower word at even, upper word at odd address.
// RULE4: Program counter stays even, steps up or down by two per word.
// RULE5: Vectors below 0x000200; reset at 0x000000; start word at 0x000002.
// RULE6: Vector tables span 0x000004-0x0000FF and 0x000100-0x0001FF.
// RULE7: Data space is 16 bits wide, separate read and write address units.
// RULE8: Data effective address is 16 bits, selecting a byte of 64 Kbytes.
// RULE9: Address top bit zero selects RAM; one selects visibility window.
// RULE10: 2 Kbytes of RAM; reads outside it return zero.
// RULE11: Low byte at even byte address, high byte at odd address.
// RULE12: Post-increment pointer advances one for bytes, two for words.
// RULE13: Byte read fetches word, address bit 0 picks byte, placed on low lane.
// RULE14: Byte write uses shared word decode, strobes only the matching lane.
// RULE15: Word access at odd address raises an address error trap.
// RULE16: Misaligned read completes; write suppressed; then the trap is taken.
// RULE17: Byte load into working register changes only its low byte.
// RULE18: Sign-extend widens 8-bit signed to 16; zero-extend clears high byte.
// RULE19: Writes outside RAM and window are ignored without side effects.
// RULE20: Trap raised by end of faulting instruction; fault state kept.
`timescale 1ns/1ps
module pdsa_core_access (
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Program counter control
  input wire logic pc_adv_i,
  input wire logic pc_dir_dn_i,
  input wire logic pc_load_i,
  input wire logic [22:0] pc_target_i,
  output logic [23:0] program_counter_o,
  output logic pc_in_vector_o,
  output logic pc_in_ivt_o,
  output logic pc_in_aivt_o,
  // Table access to program space
  input wire logic tbl_req_i,
  input wire logic table_read_op_i,
  input wire logic table_write_op_i,
  input wire logic [7:0] table_page_register_i,
  input wire logic [15:0] tbl_offset_i,
  output logic [23:0] tbl_paddr_o,
  output logic tbl_upper_word_o,
  output logic tbl_allowed_o,
  // Program space visibility fetch (from data window)
  output logic [23:0] psv_paddr_o,
  output logic psv_req_o,
  input wire logic [15:0] psv_data_i,
  input wire logic [7:0] psv_page_i,
  // Data read port (read address generation unit)
  input wire logic rd_req_i,
  input wire logic rd_byte_i,
  input wire logic [15:0] rd_ea_i,
  output logic [15:0] rd_data_o,
  // Data write port (write address generation unit)
  input wire logic wr_req_i,
  input wire logic wr_byte_i,
  input wire logic [15:0] wr_ea_i,
  input wire logic [15:0] wr_data_i,
  // Post-increment pointer arithmetic
  input wire logic [15:0] source_pointer_register_i,
  input wire logic ptr_byte_i,
  output logic [15:0] ptr_next_o,
  // Working register loads and extends
  input wire logic [3:0] wreg_sel_i,
  input wire logic wreg_byte_load_i,
  input wire logic wreg_word_load_i,
  input wire logic sign_extend_op_i,
  input wire logic zero_extend_op_i,
  input wire logic [15:0] wreg_src_i,
  output logic [15:0] wreg_rd_data_o,
  // Instruction boundary and trap
  input wire logic instr_end_i,
  output logic addr_err_trap_o,
  output logic [15:0] fault_ea_o,
  output logic fault_was_write_o
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_range(input logic [23:0] a,
                                    input logic [23:0] lo,
                                    input logic [23:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic is_ram(input logic [15:0] ea);
    is_ram = !ea[pdsa_pkg::PSV_BIT] && (ea < pdsa_pkg::RAM_END);
  endfunction

  function automatic logic [23:0] psv_map(input logic [7:0] page,
                                          input logic [15:0] ea);
    psv_map = {page, ea[14:0], 1'b0};
  endfunction

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  logic [22:0] pc_ff;
  logic [22:0] nxt_pc;
  logic [22:0] pc_step_val;

  assign pc_step_val = pc_dir_dn_i ? (pc_ff - pdsa_pkg::PC_STEP)
                                   : (pc_ff + pdsa_pkg::PC_STEP); // [RULE4]
  assign nxt_pc = pc_load_i ? {pc_target_i[22:1], 1'b0} // [RULE4]
                : pc_adv_i ? pc_step_val : pc_ff;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pc_ff <= pdsa_pkg::RESET_ADDR[22:0]; // [RULE5]
    end else begin
      pc_ff <= nxt_pc;
    end
  end

  // Bit 23 is never set by execution, keeping fetches in user half
  assign program_counter_o = {1'b0, pc_ff}; // [RULE1] [RULE2]
  assign pc_in_vector_o = program_counter_o < pdsa_pkg::VEC_END; // [RULE5]
  assign pc_in_ivt_o = in_range(program_counter_o, pdsa_pkg::IVT_LO,
                                pdsa_pkg::IVT_HI); // [RULE6]
  assign pc_in_aivt_o = in_range(program_counter_o, pdsa_pkg::AIVT_LO,
                                 pdsa_pkg::AIVT_HI); // [RULE6]

  // ----------------------------------------------------------------
  // Table access
  // ----------------------------------------------------------------
  wire tbl_op = table_read_op_i || table_write_op_i;

  assign tbl_paddr_o = {table_page_register_i, tbl_offset_i}; // [RULE1]
  assign tbl_upper_word_o = tbl_offset_i[0]; // [RULE3]
  // Table access allowed for any requested table read or write; the page bit is not checked
  assign tbl_allowed_o = tbl_req_i && tbl_op; // [RULE2]

  // ----------------------------------------------------------------
  // Data space decode
  // ----------------------------------------------------------------
  wire rd_in_psv = rd_ea_i[pdsa_pkg::PSV_BIT]; // [RULE9]
  wire rd_in_ram = is_ram(rd_ea_i); // [RULE10]
  wire wr_in_ram = is_ram(wr_ea_i); // [RULE19]
  wire rd_misal = rd_req_i && !rd_byte_i && rd_ea_i[0]; // [RULE15]
  wire wr_misal = wr_req_i && !wr_byte_i && wr_ea_i[0]; // [RULE15]

  wire [pdsa_pkg::RAM_AW-1:0] rd_word = rd_ea_i[pdsa_pkg::RAM_AW:1]; // [RULE8]
  wire [pdsa_pkg::RAM_AW-1:0] wr_word = wr_ea_i[pdsa_pkg::RAM_AW:1];
  logic [15:0] ram_rd;

  // Lane strobes: byte picks one lane, word drives both
  wire wr_ok = wr_req_i && wr_in_ram && !wr_misal; // [RULE16] [RULE19]
  wire wr_lo = wr_ok && (!wr_byte_i || !wr_ea_i[0]); // [RULE14]
  wire wr_hi = wr_ok && (!wr_byte_i || wr_ea_i[0]); // [RULE14]
  wire [15:0] wr_lane_data = wr_byte_i ? {wr_data_i[7:0], wr_data_i[7:0]}
                                       : wr_data_i; // [RULE14]

  pdsa_data_ram u_ram (
    .clk_i(clk_i),
    .rd_word_i(rd_word),
    .rd_data_o(ram_rd),
    .wr_word_i(wr_word),
    .wr_data_i(wr_lane_data),
    .wr_lo_i(wr_lo),
    .wr_hi_i(wr_hi)
  ); // [RULE7]

  // Program visibility window: request driven by read unit only
  assign psv_req_o = rd_req_i && rd_in_psv; // [RULE9]
  assign psv_paddr_o = psv_map(psv_page_i, rd_ea_i);

  wire [15:0] rd_word_val = rd_in_ram ? ram_rd
                          : rd_in_psv ? psv_data_i
                          : pdsa_pkg::ZERO_WORD; // [RULE10]
  wire [7:0] rd_byte_val = rd_ea_i[0] ? rd_word_val[15:8]
                                      : rd_word_val[7:0]; // [RULE13]
  // Misaligned read still completes with aligned data
  wire [15:0] rd_mux = rd_byte_i ? {pdsa_pkg::ZERO_BYTE, rd_byte_val}
                                 : rd_word_val; // [RULE13] [RULE16]

  logic [15:0] rd_data_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_ff <= pdsa_pkg::ZERO_WORD;
    end else if (rd_req_i) begin
      rd_data_ff <= rd_mux;
    end
  end
  assign rd_data_o = rd_data_ff;

  // ----------------------------------------------------------------
  // Pointer scaling
  // ----------------------------------------------------------------
  assign ptr_next_o = source_pointer_register_i +
                      (ptr_byte_i ? pdsa_pkg::STEP_BYTE
                                  : pdsa_pkg::STEP_WORD); // [RULE12]

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  pdsa_pkg::pdsa_wop_t wop;
  logic [15:0] wdata;
  wire [7:0] sext_hi = wreg_src_i[7] ? pdsa_pkg::ONES_BYTE
                                     : pdsa_pkg::ZERO_BYTE;

  assign wop = (sign_extend_op_i || zero_extend_op_i) ? pdsa_pkg::PDSA_WOP_EXT
             : wreg_byte_load_i ? pdsa_pkg::PDSA_WOP_BYTE
             : wreg_word_load_i ? pdsa_pkg::PDSA_WOP_WORD
             : pdsa_pkg::PDSA_WOP_NONE;
  assign wdata = sign_extend_op_i ? {sext_hi, wreg_src_i[7:0]} // [RULE18]
               : zero_extend_op_i ? {pdsa_pkg::ZERO_BYTE, wreg_src_i[7:0]}
               : wreg_src_i; // [RULE18]

  pdsa_wreg_file u_wreg (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .rd_sel_i(wreg_sel_i),
    .rd_data_o(wreg_rd_data_o),
    .wr_sel_i(wreg_sel_i),
    .wr_op_i(wop),
    .wr_data_i(wdata)
  ); // [RULE17]

  // ----------------------------------------------------------------
  // Address error trap
  // ----------------------------------------------------------------
  // Fault is held until instruction end so the handler sees pre-fault state
  logic pend_ff;
  logic trap_ff;
  logic [15:0] fault_ea_ff;
  logic fault_wr_ff;
  wire any_misal = rd_misal || wr_misal;
  wire pend_now = pend_ff || any_misal;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pend_ff <= 1'b0;
      trap_ff <= 1'b0;
      fault_ea_ff <= pdsa_pkg::ZERO_WORD;
      fault_wr_ff <= 1'b0;
    end else begin
      trap_ff <= pend_now && instr_end_i; // [RULE16] [RULE20]
      pend_ff <= pend_now && !instr_end_i; // [RULE20]
      if (any_misal && !pend_ff) begin
        fault_ea_ff <= wr_misal ? wr_ea_i : rd_ea_i; // [RULE20]
        fault_wr_ff <= wr_misal;
      end
    end
  end

  assign addr_err_trap_o = trap_ff; // [RULE15]
  assign fault_ea_o = fault_ea_ff;
  assign fault_was_write_o = fault_wr_ff;

endmodule

// file: pdsa_chk.sv
// Checker: concurrent checks on the access block ports
`timescale 1ns/1ps
module pdsa_chk (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic pc_adv_i,
  input wire logic pc_dir_dn_i,
  input wire logic pc_load_i,
  input wire logic [22:0] pc_target_i,
  input wire logic [23:0] program_counter_o,
  input wire logic pc_in_vector_o,
  input wire logic pc_in_ivt_o,
  input wire logic pc_in_aivt_o,
  input wire logic [7:0] table_page_register_i,
  input wire logic [15:0] tbl_offset_i,
  input wire logic [23:0] tbl_paddr_o,
  input wire logic tbl_upper_word_o,
  input wire logic psv_req_o,
  input wire logic [15:0] psv_data_i,
  input wire logic rd_req_i,
  input wire logic rd_byte_i,
  input wire logic [15:0] rd_ea_i,
  input wire logic [15:0] rd_data_o,
  input wire logic wr_req_i,
  input wire logic wr_byte_i,
  input wire logic [15:0] wr_ea_i,
  input wire logic [15:0] source_pointer_register_i,
  input wire logic ptr_byte_i,
  input wire logic [15:0] ptr_next_o,
  input wire logic instr_end_i,
  input wire logic addr_err_trap_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Word access at an odd byte address, either port
  wire logic misal_w = (rd_req_i & ~rd_byte_i & rd_ea_i[0]) |
                       (wr_req_i & ~wr_byte_i & wr_ea_i[0]);
  a_pc_up: assert property (
    pc_adv_i && !pc_load_i && !pc_dir_dn_i |=> program_counter_o[22:0] ==
    $past(program_counter_o[22:0]) + 23'h000002) else $error("pc up step");
  a_pc_down: assert property (
    pc_adv_i && !pc_load_i && pc_dir_dn_i |=> program_counter_o[22:0] ==
    $past(program_counter_o[22:0]) - 23'h000002) else $error("pc down step");
  a_pc_load: assert property (
    pc_load_i |=> program_counter_o == {1'b0, $past(pc_target_i[22:1]), 1'b0})
    else $error("pc load value");
  a_pc_shape: assert property (
    program_counter_o[23] == 1'b0 && program_counter_o[0] == 1'b0)
    else $error("pc out of form");
  a_vector_flags: assert property (
    pc_in_vector_o == (program_counter_o < 24'h000200) && pc_in_ivt_o ==
    (program_counter_o >= 24'h000004 && program_counter_o <= 24'h0000FF))
    else $error("vector region flag");
  a_aivt_flag: assert property (
    pc_in_aivt_o == (program_counter_o >= 24'h000100 &&
    program_counter_o <= 24'h0001FF)) else $error("alternate table flag");
  a_table_map: assert property (
    tbl_paddr_o == {table_page_register_i, tbl_offset_i} &&
    tbl_upper_word_o == tbl_offset_i[0]) else $error("table address");
  a_window_route: assert property (
    psv_req_o == (rd_req_i && rd_ea_i[15])) else $error("window routing");
  a_ptr_scale: assert property (
    ptr_next_o == source_pointer_register_i + (ptr_byte_i ? 16'h0001 :
    16'h0002)) else $error("pointer step");
  a_rd_zero: assert property (
    rd_req_i && !rd_ea_i[15] && rd_ea_i[14:11] != 4'h0 |=>
    rd_data_o == 16'h0000) else $error("unimplemented read not zero");
  a_byte_lane: assert property (
    rd_req_i && rd_byte_i |=> rd_data_o[15:8] == 8'h00)
    else $error("byte read high lane");
  a_window_word: assert property (
    rd_req_i && rd_ea_i[15] && !rd_byte_i && !rd_ea_i[0] |=>
    rd_data_o == $past(psv_data_i)) else $error("window read data");
  a_trap_raise: assert property (
    misal_w && instr_end_i |=> addr_err_trap_o) else $error("trap missing");
  a_trap_pulse: assert property (
    addr_err_trap_o |-> $past(instr_end_i) ##1
    (!addr_err_trap_o || $past(misal_w) && $past(instr_end_i)))
    else $error("trap pulse shape");
endmodule

// file: pdsa_psv_model.sv
// Partner model: program word source behind the visibility window
`timescale 1ns/1ps
module pdsa_psv_model (
  input wire logic clk_i,
  input wire logic psv_req_i,
  input wire logic [23:0] psv_paddr_i,
  output logic [15:0] psv_data_o
);
  logic [15:0] last_ff = 16'h0000;
  // Word content is a fixed scramble of the address
  wire logic [15:0] word_w = psv_paddr_i[15:0] ^ 16'hA5C3;
  // Idle bus shows the inverse of the last word, so stale data never matches
  assign psv_data_o = psv_req_i ? word_w : ~last_ff;
  always_ff @(posedge clk_i) begin
    if (psv_req_i) begin
      last_ff <= word_w;
    end
  end
endmodule

// file: tb_top.sv
// Testbench: random and corner traffic through the access block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0, rst_b_i = 1'b0, pc_adv_i = 1'b0, pc_dir_dn_i = 1'b0;
  logic pc_load_i = 1'b0, tbl_req_i = 1'b0, table_read_op_i = 1'b0;
  logic table_write_op_i = 1'b0, rd_req_i = 1'b0, rd_byte_i = 1'b0;
  logic wr_req_i = 1'b0, wr_byte_i = 1'b0, ptr_byte_i = 1'b0;
  logic wreg_byte_load_i = 1'b0, wreg_word_load_i = 1'b0;
  logic sign_extend_op_i = 1'b0, zero_extend_op_i = 1'b0, instr_end_i = 1'b0;
  logic [22:0] pc_target_i = 23'h000000;
  logic [7:0] table_page_register_i = 8'h00, psv_page_i = 8'h00;
  logic [15:0] tbl_offset_i = 16'h0000, rd_ea_i = 16'h0000;
  logic [15:0] wr_ea_i = 16'h0000, wr_data_i = 16'h0000;
  logic [15:0] source_pointer_register_i = 16'h0000, wreg_src_i = 16'h0000;
  logic [3:0] wreg_sel_i = 4'h0;
  logic [23:0] program_counter_o, tbl_paddr_o, psv_paddr_o, pc_e;
  logic pc_in_vector_o, pc_in_ivt_o, tbl_upper_word_o, tbl_allowed_o;
  logic psv_req_o, addr_err_trap_o, fault_was_write_o;
  logic [15:0] psv_data_i, rd_data_o, ptr_next_o, wreg_rd_data_o, fault_ea_o;
  logic [15:0] mem_q [0:1023];
  logic [15:0] wq [0:15];
  logic [15:0] rd_e, fea_e;
  logic rd_p, tr_e, pend, fwr_e, misal, tbl_e;
  logic [31:0] r;
  int errors = 0, checks = 0, seed = 57450, i;

  pdsa_core_access DUT (.clk_i, .rst_b_i, .pc_adv_i, .pc_dir_dn_i,
    .pc_load_i, .pc_target_i, .program_counter_o, .pc_in_vector_o,
    .pc_in_ivt_o, .pc_in_aivt_o(), .tbl_req_i, .table_read_op_i,
    .table_write_op_i, .table_page_register_i, .tbl_offset_i, .tbl_paddr_o,
    .tbl_upper_word_o, .tbl_allowed_o, .psv_paddr_o, .psv_req_o, .psv_data_i,
    .psv_page_i, .rd_req_i, .rd_byte_i, .rd_ea_i, .rd_data_o, .wr_req_i,
    .wr_byte_i, .wr_ea_i, .wr_data_i, .source_pointer_register_i, .ptr_byte_i,
    .ptr_next_o, .wreg_sel_i, .wreg_byte_load_i, .wreg_word_load_i,
    .sign_extend_op_i, .zero_extend_op_i, .wreg_src_i, .wreg_rd_data_o,
    .instr_end_i, .addr_err_trap_o, .fault_ea_o, .fault_was_write_o);
  pdsa_psv_model u_psv (.clk_i, .psv_req_i(psv_req_o),
    .psv_paddr_i(psv_paddr_o), .psv_data_o(psv_data_i));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic cmp_v(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_v({23'h000000, got}, {23'h000000, exp});
  endtask

  task automatic finish_test;
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Window words scramble the address; RAM holds words; else zero
  function automatic logic [15:0] exp_rd(input logic [15:0] ea,
                                         input logic b);
    logic [15:0] w;
    if (ea[15]) w = {ea[14:0], 1'b0} ^ 16'hA5C3;
    else if (ea[14:11] == 4'h0) w = mem_q[ea[10:1]];
    else w = 16'h0000;
    if (b) w = ea[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    return w;
  endfunction

  // ----------------------------------------
  // Main sequence: fill RAM, then random mix
  // ----------------------------------------
  initial begin
    foreach (wq[k]) wq[k] = 16'h0000;
    {rd_p, tr_e, pend, fwr_e, fea_e, pc_e, tbl_e} = '0;
    repeat (3) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    cmp_v(program_counter_o, 24'h000000);
    cmp_v(rd_data_o, 16'h0000);
    for (i = 0; i < 4000; i++) begin
      @(posedge clk_i);
      #1;
      if (rd_p) cmp_v(rd_data_o, rd_e);
      cmp_v(program_counter_o, pc_e);
      cmp_v(wreg_rd_data_o, wq[wreg_sel_i]);
      cmp_b(addr_err_trap_o, tr_e);
      if (tr_e) cmp_v(fault_ea_o, fea_e);
      if (tr_e) cmp_b(fault_was_write_o, fwr_e);
      cmp_b(tbl_allowed_o, tbl_e);
      r = $random(seed);
      pc_load_i = r[0] & r[1];
      pc_adv_i = r[2];
      pc_dir_dn_i = r[3];
      pc_target_i = r[4] ? 23'($random(seed)) : {13'h0000, r[14:5]};
      if (pc_load_i) pc_e = {1'b0, pc_target_i[22:1], 1'b0};
      else if (pc_adv_i) pc_e[22:0] = pc_dir_dn_i ? pc_e[22:0] - 23'h000002
                                                : pc_e[22:0] + 23'h000002;
      // Separate read and write ports, never both in one cycle
      rd_ea_i = 16'($random(seed));
      if (r[16]) rd_ea_i[15:11] = 5'h00;
      wr_ea_i = (i < 1024) ? 16'(i * 2) : rd_ea_i;
      wr_data_i = 16'($random(seed));
      rd_byte_i = r[17];
      wr_byte_i = r[17] & (i >= 1024);
      rd_req_i = r[18] & (i >= 1024);
      wr_req_i = ~rd_req_i & (r[19] | (i < 1024));
      psv_page_i = r[12:5];
      rd_p = rd_req_i;
      rd_e = exp_rd(rd_ea_i, rd_byte_i);
      // Word access at odd address is the core misbehaving on purpose
      misal = (rd_req_i & ~rd_byte_i & rd_ea_i[0]) |
              (wr_req_i & ~wr_byte_i & wr_ea_i[0]);
      if (wr_req_i && wr_ea_i[15:11] == 5'h00 && !misal) begin
        if (!wr_byte_i) mem_q[wr_ea_i[10:1]] = wr_data_i;
        else if (wr_ea_i[0])
          mem_q[wr_ea_i[10:1]][15:8] = wr_data_i[7:0];
        else mem_q[wr_ea_i[10:1]][7:0] = wr_data_i[7:0];
      end
      instr_end_i = r[20] & (i >= 1024);
      if (misal && !pend) begin
        fea_e = rd_req_i ? rd_ea_i : wr_ea_i;
        fwr_e = wr_req_i;
      end
      tr_e = (pend | misal) & instr_end_i;
      pend = (pend | misal) & ~instr_end_i;
      wreg_sel_i = r[24:21];
      wreg_src_i = 16'($random(seed));
      {sign_extend_op_i, zero_extend_op_i, wreg_byte_load_i, wreg_word_load_i}
        = r[27] ? 4'h0 : 4'h1 << r[26:25];
      if (sign_extend_op_i)
        wq[wreg_sel_i] = {{8{wreg_src_i[7]}}, wreg_src_i[7:0]};
      if (zero_extend_op_i)
        wq[wreg_sel_i] = {8'h00, wreg_src_i[7:0]};
      if (wreg_byte_load_i) wq[wreg_sel_i][7:0] = wreg_src_i[7:0];
      if (wreg_word_load_i) wq[wreg_sel_i] = wreg_src_i;
      {tbl_req_i, table_read_op_i, table_write_op_i} = r[30:28];
      tbl_e = r[30] & (r[29] | r[28]);
      table_page_register_i = 8'($random(seed));
      tbl_offset_i = 16'($random(seed));
      source_pointer_register_i = 16'($random(seed));
      ptr_byte_i = r[31];
    end
    finish_test();
  end

  initial begin
    #150000;
    errors++;
    finish_test();
  end
endmodule

bind pdsa_core_access pdsa_chk u_chk (.clk_i, .rst_b_i, .pc_adv_i,
  .pc_dir_dn_i, .pc_load_i, .pc_target_i, .program_counter_o, .pc_in_vector_o,
  .pc_in_ivt_o, .pc_in_aivt_o, .table_page_register_i, .tbl_offset_i,
  .tbl_paddr_o,
  .tbl_upper_word_o, .psv_req_o, .psv_data_i, .rd_req_i, .rd_byte_i, .rd_ea_i,
  .rd_data_o, .wr_req_i, .wr_byte_i, .wr_ea_i, .source_pointer_register_i,
  .ptr_byte_i, .ptr_next_o, .instr_end_i, .addr_err_trap_o);
